// *** verilog/ras_stack.v ***
`timescale 1ns/1ps
`include "ras_regs.vh"

// the flag has three states. open lets it follow the pointer. under marks a
// pop with no push since reset, which makes the stack look full. locked holds
// it clear until the next reset; a push from the last slot or any push while
// still in under, idle cycles or not, leads there. a second pop out of under goes back to
// open, so only a push makes an underflow permanent.
// limitation: overwritten entries are dropped without a mark; the caller sees
// it only as a flag that stays low.
module ras_stack #(
   parameter DEPTH = `RAS_DEPTH,
   parameter PTR_W = `RAS_PTR_W,
   parameter DATA_W = `RAS_DATA_W
) (
   // clock and reset
   input  wire              clk,
   input  wire              rst_n,
   // push requests from the sequencer
   input  wire              callExec,
   input  wire              intVector,
   input  wire [DATA_W-1:0] pcIn,
   // pop request and popped value
   input  wire              retExec,
   output reg  [DATA_W-1:0] pcOut_r,
   output reg               pcOutValid_r,
   // status
   output wire              stackSpaceAvailable
);
   // flag states, one-hot
   localparam [2:0] ST_OPEN   = 3'h1; // normal, flag follows the pointer
   localparam [2:0] ST_UNDER  = 3'h2; // popped before any push
   localparam [2:0] ST_LOCKED = 3'h4; // cleared until reset

   // pointer constants sized to the pointer, so no sum or compare pads bits
   localparam [PTR_W-1:0] PTR_ONE   = {{(PTR_W-1){1'b0}}, 1'b1};
   localparam [PTR_W-1:0] PTR_LAST  = `RAS_PTR_LAST;
   localparam [PTR_W-1:0] PTR_RESET = `RAS_PTR_RESET;

   // pointer after a push; the plain wrap of the counter makes the ring
   function [PTR_W-1:0] ptrAfterPush;
      input [PTR_W-1:0] p;
      begin
         ptrAfterPush = p + PTR_ONE;
      end
   endfunction

   // pointer after a pop, which is also the slot that the pop reads
   function [PTR_W-1:0] ptrAfterPop;
      input [PTR_W-1:0] p;
      begin
         ptrAfterPop = p - PTR_ONE;
      end
   endfunction

   // pointer on the last slot; drives the flag and spots the rollover
   function atLast;
      input [PTR_W-1:0] p;
      begin
         atLast = (p == PTR_LAST);
      end
   endfunction

   reg  [PTR_W-1:0] ptr_r;
   reg  [PTR_W-1:0] ptr_nxt;
   reg  [2:0]       state_r;
   reg  [2:0]       state_nxt;
   reg              avail_r;
   reg              avail_nxt;
   reg              pushed_r;   // any push since reset
   wire             push;
   wire             pop;
   wire [PTR_W-1:0] popIdx;
   wire [DATA_W-1:0] rdData;
   // steering events for the flag
   wire             rollover;
   wire             underflow;

   // a call and an interrupt vector both push; a return that shares the cycle
   // with a push is dropped, and the push goes ahead, as the sequencer may ask for both
   assign push   = callExec | intVector;
   assign pop    = retExec & ~push;
   assign popIdx = ptrAfterPop(ptr_r);

   // events that steer the flag: a push from the last slot wraps the ring,
   // and a pop with no push since reset reads past the bottom
   assign rollover  = push & atLast(ptr_r);
   assign underflow = pop & ~pushed_r;
   // the pc high latch lives in the core and has no path into this block
   assign stackSpaceAvailable = avail_r;

   // the entries sit in flip-flops of their own, outside every address space
   ras_store #(
      .DEPTH  (DEPTH),
      .PTR_W  (PTR_W),
      .DATA_W (DATA_W)
   ) uStore (
      .clk    (clk),
      .rst_n  (rst_n),
      .wrEn   (push),
      .wrIdx  (ptr_r),
      .wrData (pcIn),
      .rdIdx  (popIdx),
      .rdData (rdData)
   );

   // pointer moves modulo depth; natural wrap makes the buffer circular
   // a push writes at the pointer before it moves, a pop moves before it reads
   always @* begin
      ptr_nxt = ptr_r;
      if (push) begin
         ptr_nxt = ptrAfterPush(ptr_r);
      end else if (pop) begin
         ptr_nxt = popIdx;
      end
   end

   // flag control; lock wins over everything but reset. an underflow pop is
   // tested before the rollover, though both never fall in one cycle, as
   // one is a pop and the other a push
   always @* begin
      state_nxt = state_r;
      avail_nxt = avail_r;
      case (state_r)
         ST_OPEN: begin
            if (underflow) begin
               state_nxt = ST_UNDER;
               avail_nxt = 1'b0;
            end else if (rollover) begin
               state_nxt = ST_LOCKED;
               avail_nxt = 1'b0;
            end else begin
               avail_nxt = ~atLast(ptr_nxt);
            end
         end
         ST_UNDER: begin
            avail_nxt = 1'b0;
            if (push) begin
               state_nxt = ST_LOCKED;
            end else if (pop) begin
               // another pop leaves underflow; flag follows the pointer again
               state_nxt = ST_OPEN;
               avail_nxt = ~atLast(ptr_nxt);
            end
         end
         ST_LOCKED: begin
            avail_nxt = 1'b0;
         end
         default: begin
            state_nxt = ST_LOCKED;
            avail_nxt = 1'b0;
         end
      endcase
   end

   // pointer register; every reset puts it back at the bottom slot
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_r <= PTR_RESET;
      end else begin
         ptr_r <= ptr_nxt;
      end
   end

   // flag state register; only a reset leaves the locked state
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_OPEN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // space flag register; a reset sets it whatever came before
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avail_r <= `RAS_AVAIL_RESET;
      end else begin
         avail_r <= avail_nxt;
      end
   end

   // remembers any push since reset; tells an underflow pop from a pop that
   // wraps below a stack that was filled and emptied again
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pushed_r <= 1'b0;
      end else if (push) begin
         pushed_r <= 1'b1;
      end
   end

   // popped value is registered; valid for one cycle after the pop
   // pcOut_r keeps the last popped value, so a late reader still finds it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pcOut_r      <= {DATA_W{1'b0}};
         pcOutValid_r <= 1'b0;
      end else begin
         pcOutValid_r <= pop;
         if (pop) begin
            pcOut_r <= rdData;
         end
      end
   end
endmodule

// *** inc/ras_regs.vh ***
`ifndef RAS_REGS_VH
`define RAS_REGS_VH
// stack geometry
`define RAS_DEPTH        16
`define RAS_PTR_W        4
`define RAS_DATA_W       16
// pointer reset value and the value that drops the space flag
`define RAS_PTR_RESET    4'h0
`define RAS_PTR_LAST     4'hf
// space flag reset value
`define RAS_AVAIL_RESET  1'b1
`endif

// *** verilog/ras_store.v ***
`timescale 1ns/1ps
`include "ras_regs.vh"
// flip-flop storage for the saved program counters, one write port
module ras_store #(
   parameter DEPTH = `RAS_DEPTH,
   parameter PTR_W = `RAS_PTR_W,
   parameter DATA_W = `RAS_DATA_W
) (
   // clock and reset
   input  wire              clk,
   input  wire              rst_n,
   // write port
   input  wire              wrEn,
   input  wire [PTR_W-1:0]  wrIdx,
   input  wire [DATA_W-1:0] wrData,
   // read port
   input  wire [PTR_W-1:0]  rdIdx,
   output wire [DATA_W-1:0] rdData
);
   reg  [DATA_W-1:0] mem_r [0:DEPTH-1];
   wire [DEPTH-1:0]  wrSel;
   genvar g;

   // one-hot slot select, so no slot index is compared with a wide integer
   assign wrSel = {{(DEPTH-1){1'b0}}, 1'b1} << wrIdx;

   // one register per entry; a write at the pointer overwrites the oldest on wrap
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : gEntry
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               mem_r[g] <= {DATA_W{1'b0}};
            end else if (wrEn && wrSel[g]) begin
               mem_r[g] <= wrData;
            end
         end
      end
   endgenerate

   assign rdData = mem_r[rdIdx];
endmodule

// *** testbench/ras_stack_asserts.sv ***
`timescale 1ns/1ps
// port checker; a pop that shares its cycle with a push is dropped
module ras_chk (
   // clock and reset
   input logic        clk,
   input logic        rst_n,
   // requests
   input logic        callExec,
   input logic        intVector,
   input logic        retExec,
   input logic [15:0] pcIn,
   // results
   input logic [15:0] pcOut_r,
   input logic        pcOutValid_r,
   input logic        stackSpaceAvailable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // decoded requests, push wins
   wire psh = callExec | intVector;
   wire pp  = retExec & ~psh;
   a_pop_valid: assert property (pp |=> pcOutValid_r)
      else $error("pop gave no valid");
   a_no_spur: assert property (!pp |=> !pcOutValid_r)
      else $error("valid without pop");
   a_out_hold: assert property (!pp |=> $stable(pcOut_r))
      else $error("output moved without pop");
   a_push_pop: assert property (psh ##1 pp |=> pcOut_r == $past(pcIn, 2))
      else $error("pop missed last push");
   a_reset_avail: assert property ($rose(rst_n) |-> stackSpaceAvailable)
      else $error("flag low after reset");
   a_idle_flag: assert property (!psh && !pp |=> $stable(stackSpaceAvailable))
      else $error("flag moved when idle");
   a_flag_lock: assert property (psh && !stackSpaceAvailable
      |=> !stackSpaceAvailable)
      else $error("flag left lock");
   a_rise_pop: assert property ($rose(stackSpaceAvailable) |-> $past(pp))
      else $error("flag rose without pop");
endmodule
bind ras_stack ras_chk u_chk (.clk(clk), .rst_n(rst_n), .callExec(callExec),
   .intVector(intVector), .retExec(retExec), .pcIn(pcIn), .pcOut_r(pcOut_r),
   .pcOutValid_r(pcOutValid_r), .stackSpaceAvailable(stackSpaceAvailable));

// *** testbench/ras_seq.sv ***
`timescale 1ns/1ps
// sequencer model: one op per cycle, its request lines set at the falling edge
module ras_seq (
   // clock
   input  logic        clk,
   // requests
   output logic        callExec,
   output logic        intVector,
   output logic        retExec,
   output logic [15:0] pcIn,
   // popped value
   input  logic [15:0] pcOut_r,
   input  logic        pcOutValid_r
);
   logic [15:0] pc;
   initial {callExec, intVector, retExec, pcIn} = 19'h0;
   // k is {call, vector, return}; one op per cycle, bits may be combined
   task op(input logic [2:0] k, input logic [15:0] v);
      @(negedge clk);
      {callExec, intVector, retExec} = k;
      pcIn = v;
   endtask
   // idle keeps pcIn toggling so a stale value is never trusted
   task idle;
      op(3'h0, ~pcIn);
   endtask
   // popped value goes back into the program counter
   always @(posedge clk) if (pcOutValid_r) pc <= pcOut_r;
endmodule

// *** testbench/ras_stack_tb_top.sv ***
`timescale 1ns/1ps
module ras_stack_tb_top;
   logic        clk = 0, rst_n = 0, callExec, intVector, retExec;
   logic        pcOutValid_r, stackSpaceAvailable;
   logic [15:0] pcIn, pcOut_r;
   int          n_errors = 0, n_checks = 0;
   always #2 clk = ~clk;
   ras_seq seq (.clk(clk), .callExec(callExec), .intVector(intVector), .retExec(retExec),
      .pcIn(pcIn), .pcOut_r(pcOut_r), .pcOutValid_r(pcOutValid_r));
   ras_stack dut (.clk(clk), .rst_n(rst_n), .callExec(callExec), .intVector(intVector),
      .retExec(retExec), .pcIn(pcIn), .pcOut_r(pcOut_r), .pcOutValid_r(pcOutValid_r),
      .stackSpaceAvailable(stackSpaceAvailable));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task fl(input logic e);
      chk({15'h0, stackSpaceAvailable}, {15'h0, e});
   endtask
   task vl(input logic e);
      chk({15'h0, pcOutValid_r}, {15'h0, e});
   endtask
   task end_sim;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task rst;
      @(negedge clk) rst_n = 0;
      repeat (10) @(negedge clk);
      rst_n = 1;
   endtask
   // pop; pulse and value while they stand, then the pulse gone and the model's pc
   task pop(input logic [15:0] e);
      seq.op(3'h1, 16'h0);
      seq.idle;
      vl(1'b1);
      chk(pcOut_r, e);
      seq.idle;
      vl(1'b0);
      chk(seq.pc, e);
   endtask
   // all push sources, a push that beats a pop, pops spaced by two idle cycles
   task t_lifo;
      rst;
      seq.op(3'h4, 16'ha001);
      seq.op(3'h2, 16'hb002);
      seq.op(3'h5, 16'hc003);
      seq.op(3'h4, 16'hd004);
      pop(16'hd004);
      pop(16'hc003);
      pop(16'hb002);
      pop(16'ha001);
      fl(1'b1);
      pop(16'h0000);
      fl(1'b0);
      $display("lifo done");
   endtask
   // fill to fifteen, step back, then roll over and overwrite the oldest
   task t_wrap;
      int i;
      rst;
      for (i = 1; i <= 15; i++) seq.op(3'h4, 16'(i));
      seq.idle;
      fl(1'b0);
      pop(16'h000f);
      fl(1'b1);
      for (i = 15; i <= 18; i++) seq.op(3'h2, 16'(i));
      for (i = 18; i >= 3; i--) pop(16'(i));
      fl(1'b0);
      $display("wrap done");
   endtask
   // underflow shows full, a push locks it, a second pop recovers instead
   task t_under;
      rst;
      fl(1'b1);
      pop(16'h0000);
      fl(1'b0);
      seq.op(3'h4, 16'h1234);
      pop(16'h1234);
      fl(1'b0);
      rst;
      pop(16'h0000);
      pop(16'h0000);
      fl(1'b1);
      $display("underflow done");
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      end_sim;
   end
   initial begin
      t_lifo;
      t_wrap;
      t_under;
      end_sim;
   end
endmodule
